// ===== verilog/fcrsc_regs.vh
`ifndef FCRSC_REGS_VH
`define FCRSC_REGS_VH
// register offsets
`define FCRSC_OFS_MODE      8'h0D
`define FCRSC_OFS_ROUTE_STS 8'h0E
`define FCRSC_OFS_FIFO_SEL  8'h0F
`define FCRSC_OFS_CONN      8'hFA
`define FCRSC_OFS_SUBCH     8'hFB
`define FCRSC_OFS_CHAN      8'hFC
// connection register fields
`define FCRSC_CONN_TRP      1
`define FCRSC_CONN_IRQ_LO   2
`define FCRSC_CONN_IRQ_HI   4
`define FCRSC_CONN_FLOW_LO  5
`define FCRSC_CONN_FLOW_HI  7
// subchannel register fields
`define FCRSC_SUB_CNT_LO    0
`define FCRSC_SUB_CNT_HI    2
`define FCRSC_SUB_START_LO  3
`define FCRSC_SUB_START_HI  5
`define FCRSC_SUB_LOOP      6
`define FCRSC_SUB_INV       7
// channel assignment fields
`define FCRSC_CHAN_DIR      0
`define FCRSC_CHAN_NUM_LO   1
`define FCRSC_CHAN_NUM_HI   4
// operating modes
`define FCRSC_MODE_SIMPLE   2'h0
`define FCRSC_MODE_CHSEL    2'h1
`define FCRSC_MODE_SEQ      2'h2
// reset values
`define FCRSC_RST_CONN      8'h00
`define FCRSC_RST_SUBCH     8'h00
`define FCRSC_RST_SEL       8'h00
`define FCRSC_RST_MODE      8'h00
`endif

// ===== verilog/fcrsc_slot_proc.v
`timescale 1ns/1ps
`default_nettype none
module fcrsc_slot_proc
(
  // subchannel setup
  input  wire [2:0] bit_cnt,
  input  wire [2:0] start_bit,
  input  wire       invert,
  // 1: place fifo bits into slot byte, 0: take bits out of slot byte
  input  wire       to_slot,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg  [3:0] nbits
);
  reg [7:0] mask;
  reg [7:0] inv_in;

  // field mask from count and start; count zero means the whole byte
  always @*
  begin
    nbits = (bit_cnt == 3'h0) ? 4'h8 : {1'b0, bit_cnt};
    mask = (bit_cnt == 3'h0) ? 8'hFF : (8'hFF >> (4'h8 - {1'b0, bit_cnt}));
    mask = mask << start_bit;
    inv_in = invert ? ~data_in : data_in;
    if (to_slot)
      data_out = ((inv_in << start_bit) & mask) | ~mask; // unused bits idle high
    else
      data_out = (inv_in & mask) >> start_bit;
  end
endmodule
`default_nettype wire

// ===== verilog/fcrsc_top.v
// Function
// - transmit fifo flow code picks line/pcm destinations of fifo and line data.
// - receive fifo flow code picks fifo source and optional pcm to line feed.
// - line/pcm direct connections carry data only with nonzero interrupt field.
// - pcm data sent to line via receive fifo is also stored in fifo only when flow bit 0 picks pcm as fifo source.
// - line to pcm belongs to transmit fifo and raises no fifo event.
// - hdlc mode moves exactly the configured bit count; code 000 means 8.
// - transparent mode moves whole bytes, only counted bits valid.
// - count codes 001 to 111 mean one to seven bits.
// - bit field starts at start bit field, bits 5 to 3.
// - loop bit repeats current fifo data on transmit transparent fifos only.
// - invert bit inverts channel data, else data passes unchanged.
// - channel assignment used only in channel select and sequence modes.
// - channel register holds direction in bit 0, number in bits 4 to 1.
// - channel assignment resets to the fifo's own number and direction.
// - fifo with zero interrupt field is disabled and moves no data.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "fcrsc_regs.vh"
module fcrsc_top
#(
  parameter NUM_FIFOS = 16
)
(
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // slot stream in, one slot per valid cycle
  input  wire       slot_valid,
  input  wire [3:0] slot_num,
  input  wire       slot_dir,
  input  wire [7:0] fifo_rd_data,
  input  wire [7:0] line_rx_data,
  input  wire [7:0] pcm_rx_data,
  // fifo side results
  output reg        fifo_rd_take,
  output reg        fifo_wr_valid,
  output reg  [7:0] fifo_wr_data,
  output reg  [3:0] fifo_bits,
  output reg  [4:0] fifo_index,
  output reg        fifo_event,
  // line and pcm outputs
  output reg        line_tx_valid,
  output reg  [7:0] line_tx_data,
  output reg        pcm_tx_valid,
  output reg  [7:0] pcm_tx_data
);
  localparam ENTRIES = 2 * NUM_FIFOS;

  // per-fifo arrays, index is {number, direction}
  reg  [7:0] conn_q  [0:ENTRIES-1];
  reg  [7:0] subch_q [0:ENTRIES-1];
  reg  [4:0] chan_q  [0:ENTRIES-1];
  reg  [7:0] sel_q;
  reg  [1:0] mode_q;
  integer    i;
  // one loop variable per process, a shared one would have two drivers
  integer    j;

  wire [4:0] sel_idx;
  wire       wr_conn;
  wire       wr_subch;
  wire       wr_chan;

  assign sel_idx  = sel_q[4:0];
  assign wr_conn  = reg_wr && (reg_addr == `FCRSC_OFS_CONN);
  assign wr_subch = reg_wr && (reg_addr == `FCRSC_OFS_SUBCH);
  assign wr_chan  = reg_wr && (reg_addr == `FCRSC_OFS_CHAN);

  // global registers: fifo select and operating mode
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_q  <= `FCRSC_RST_SEL;
      mode_q <= 2'h0;
    end
    else
    begin
      if (reg_wr && (reg_addr == `FCRSC_OFS_FIFO_SEL))
        sel_q <= {3'h0, reg_wdata[4:0]};
      if (reg_wr && (reg_addr == `FCRSC_OFS_MODE))
        mode_q <= reg_wdata[1:0];
    end
  end

  // per-fifo registers; writes land on the selected fifo
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (i = 0; i < ENTRIES; i = i + 1)
      begin
        conn_q[i]  <= `FCRSC_RST_CONN;
        subch_q[i] <= `FCRSC_RST_SUBCH;
        chan_q[i]  <= i[4:0];
      end
    end
    else
    begin
      if (wr_conn)
        conn_q[sel_idx] <= reg_wdata;
      if (wr_subch)
        subch_q[sel_idx] <= reg_wdata;
      if (wr_chan)
        chan_q[sel_idx] <= reg_wdata[`FCRSC_CHAN_NUM_HI:`FCRSC_CHAN_DIR];
    end
  end

  // selected fifo decode for the status read
  wire [7:0] sel_conn;
  wire [2:0] sel_flow;
  wire       sel_en;
  reg  [7:0] route_sts;

  assign sel_conn = conn_q[sel_idx];
  assign sel_flow = sel_conn[`FCRSC_CONN_FLOW_HI:`FCRSC_CONN_FLOW_LO];
  assign sel_en   = (sel_conn[`FCRSC_CONN_IRQ_HI:`FCRSC_CONN_IRQ_LO] != 3'h0);

  // status: enable, fifo->line, fifo->pcm, line->pcm, line->fifo, pcm->fifo, pcm->line
  always @*
  begin
    route_sts = 8'h00;
    route_sts[0] = sel_en;
    if (sel_en && !sel_idx[0])
    begin
      route_sts[1] = !sel_flow[1];
      // fifo reaches pcm only with codes 0xx; 1xx feeds pcm from the line
      route_sts[2] = !sel_flow[2];
      route_sts[3] = sel_flow[2];
    end
    else if (sel_en)
    begin
      route_sts[4] = !sel_flow[0];
      route_sts[5] = sel_flow[0];
      route_sts[6] = sel_flow[1];
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `FCRSC_OFS_MODE      : reg_rdata <= {6'h00, mode_q};
        `FCRSC_OFS_ROUTE_STS : reg_rdata <= route_sts;
        `FCRSC_OFS_FIFO_SEL  : reg_rdata <= sel_q;
        `FCRSC_OFS_CONN      : reg_rdata <= sel_conn;
        `FCRSC_OFS_SUBCH     : reg_rdata <= subch_q[sel_idx];
        `FCRSC_OFS_CHAN      : reg_rdata <= {3'h0, chan_q[sel_idx]};
        default              : reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // slot to fifo lookup
  reg        hit;
  reg  [4:0] fidx;
  wire       use_chan;

  assign use_chan = (mode_q == `FCRSC_MODE_CHSEL) || (mode_q == `FCRSC_MODE_SEQ);

  // first matching fifo wins; an unclaimed slot moves nothing
  // a remapped low fifo shadows the slot's own owner
  always @*
  begin
    hit  = 1'b0;
    fidx = {slot_num, slot_dir};
    if (use_chan)
    begin
      for (j = 0; j < ENTRIES; j = j + 1)
      begin
        if (!hit && (chan_q[j] == {slot_num, slot_dir}))
        begin
          hit  = 1'b1;
          fidx = j[4:0];
        end
      end
    end
    else
      hit = 1'b1;
  end

  // configuration of the fifo that owns this slot
  wire [7:0] f_conn;
  wire [7:0] f_sub;
  wire [2:0] f_flow;
  wire       f_en;
  wire       f_trp;
  wire       f_rx;
  wire       f_loop;

  assign f_conn = conn_q[fidx];
  assign f_sub  = subch_q[fidx];
  assign f_flow = f_conn[`FCRSC_CONN_FLOW_HI:`FCRSC_CONN_FLOW_LO];
  assign f_en   = (f_conn[`FCRSC_CONN_IRQ_HI:`FCRSC_CONN_IRQ_LO] != 3'h0);
  assign f_trp  = f_conn[`FCRSC_CONN_TRP];
  assign f_rx   = fidx[0];
  assign f_loop = f_sub[`FCRSC_SUB_LOOP] && !f_rx && f_trp;

  // transmit insertion and receive extraction share the bit processor
  wire [7:0] rx_src;
  wire [7:0] proc_out;
  wire [3:0] proc_bits;

  assign rx_src = f_flow[0] ? pcm_rx_data : line_rx_data;

  // start bit placement
  // field shifted to its start bit, bits outside idle high on transmit
  // count decode in processor
  fcrsc_slot_proc u_proc
  (
    .bit_cnt   (f_sub[`FCRSC_SUB_CNT_HI:`FCRSC_SUB_CNT_LO]),
    .start_bit (f_sub[`FCRSC_SUB_START_HI:`FCRSC_SUB_START_LO]),
    .invert    (f_sub[`FCRSC_SUB_INV]),
    .to_slot   (!f_rx),
    .data_in   (f_rx ? rx_src : fifo_rd_data),
    .data_out  (proc_out),
    .nbits     (proc_bits)
  );

  // routing decision for this slot
  reg        go;
  reg        n_rd;
  reg        n_wr;
  reg        n_line;
  reg  [7:0] n_line_d;
  reg        n_pcm;
  reg  [7:0] n_pcm_d;
  reg        n_evt;

  always @*
  begin
    go       = slot_valid && hit && f_en;
    n_rd     = 1'b0;
    n_wr     = 1'b0;
    n_line   = 1'b0;
    n_line_d = 8'hFF;
    n_pcm    = 1'b0;
    n_pcm_d  = 8'hFF;
    n_evt    = 1'b0;
    if (go && !f_rx)
    begin
      case (f_flow[2:1])
        2'h0:
        begin
          n_line   = 1'b1;
          n_line_d = proc_out;
          n_pcm    = 1'b1;
          n_pcm_d  = proc_out;
        end
        2'h1:
        begin
          n_pcm    = 1'b1;
          n_pcm_d  = proc_out;
        end
        2'h2:
        begin
          n_line   = 1'b1;
          n_line_d = proc_out;
          n_pcm    = 1'b1;
          n_pcm_d  = line_rx_data;
        end
        default:
        begin
          n_pcm    = 1'b1;
          n_pcm_d  = line_rx_data;
        end
      endcase
      n_rd  = (f_flow[2:1] != 2'h3) && !f_loop;
      n_evt = (f_flow[2:1] != 2'h3);
    end
    else if (go)
    begin
      n_wr  = 1'b1;
      n_evt = 1'b1;
      if (f_flow[1])
      begin
        n_line   = 1'b1;
        n_line_d = pcm_rx_data;
      end
    end
  end

  // registered outputs
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fifo_rd_take  <= 1'b0;
      fifo_wr_valid <= 1'b0;
      fifo_wr_data  <= 8'h00;
      fifo_bits     <= 4'h0;
      fifo_index    <= 5'h00;
      fifo_event    <= 1'b0;
      line_tx_valid <= 1'b0;
      line_tx_data  <= 8'hFF;
      pcm_tx_valid  <= 1'b0;
      pcm_tx_data   <= 8'hFF;
    end
    else
    begin
      fifo_rd_take  <= n_rd;
      fifo_wr_valid <= n_wr;
      fifo_wr_data  <= proc_out;
      fifo_bits     <= f_trp ? 4'h8 : proc_bits;
      fifo_index    <= fidx;
      fifo_event    <= n_evt;
      line_tx_valid <= n_line;
      line_tx_data  <= n_line_d;
      pcm_tx_valid  <= n_pcm;
      pcm_tx_data   <= n_pcm_d;
    end
  end
endmodule
`default_nettype wire

// ===== verification/fcrsc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fcrsc_checker
(
  // clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // watched ports
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       slot_valid,
  input wire logic       fifo_rd_take,
  input wire logic       fifo_wr_valid,
  input wire logic [3:0] fifo_bits,
  input wire logic [4:0] fifo_index,
  input wire logic       fifo_event,
  input wire logic       line_tx_valid,
  input wire logic [7:0] line_tx_data,
  input wire logic       pcm_tx_valid,
  input wire logic [7:0] pcm_tx_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // no slot taken, or an rx fifo feeding the line
  sequence s_idle; !slot_valid; endsequence
  sequence s_rx_feed; line_tx_valid && fifo_index[0]; endsequence
  property p_rd_once; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rd_once: assert property (p_rd_once) else $error("stale read data");
  property p_quiet; s_idle |=> !(fifo_event || line_tx_valid || pcm_tx_valid); endproperty
  a_quiet: assert property (p_quiet) else $error("output without slot");
  property p_line_idle; !line_tx_valid |-> line_tx_data == 8'hFF; endproperty
  a_line_idle: assert property (p_line_idle) else $error("line idle not ones");
  property p_pcm_idle; !pcm_tx_valid |-> pcm_tx_data == 8'hFF; endproperty
  a_pcm_idle: assert property (p_pcm_idle) else $error("pcm idle not ones");
  property p_take_tx; fifo_rd_take |-> fifo_event && !fifo_index[0]; endproperty
  a_take_tx: assert property (p_take_tx) else $error("bad fifo take");
  property p_rx_feed; s_rx_feed |-> fifo_wr_valid && fifo_event; endproperty
  a_rx_feed: assert property (p_rx_feed) else $error("fed data not stored");
  property p_bits; fifo_wr_valid |-> fifo_bits inside {[4'h1:4'h8]}; endproperty
  a_bits: assert property (p_bits) else $error("bit count out of range");
  // line to pcm alone never touches the fifo
  property p_bypass; pcm_tx_valid && !fifo_event |-> !fifo_rd_take && !fifo_wr_valid; endproperty
  a_bypass: assert property (p_bypass) else $error("bypass touched fifo");
endmodule
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // stimulus, defined from time zero
  logic        clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slot_dir = 1'b0;
  logic        slot_valid = 1'b0, rd_p = 1'b0, sl_p = 1'b0;
  logic [3:0]  slot_num = 4'h0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, fifo_rd_data = 8'h00;
  logic [7:0]  line_rx_data = 8'h00, pcm_rx_data = 8'h00, cn, sb;
  logic [4:0]  ix;
  // design outputs
  logic [7:0]  reg_rdata, fifo_wr_data, line_tx_data, pcm_tx_data;
  logic [4:0]  fifo_index;
  logic [3:0]  fifo_bits;
  logic        fifo_rd_take, fifo_wr_valid, fifo_event, line_tx_valid, pcm_tx_valid;
  // expected results, oldest first
  logic [7:0]  rd_q[$];
  logic [37:0] sl_q[$];
  int          failures = 0, n_compared = 0, seed = 32'h602d;

  fcrsc_top i_dut
  (
    .clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .slot_valid,
    .slot_num, .slot_dir, .fifo_rd_data, .line_rx_data, .pcm_rx_data, .fifo_rd_take,
    .fifo_wr_valid, .fifo_wr_data, .fifo_bits, .fifo_index, .fifo_event, .line_tx_valid,
    .line_tx_data, .pcm_tx_valid, .pcm_tx_data
  );

  always #25 clk = ~clk;
  // a result shows one cycle after its request
  always @(posedge clk)
  begin
    rd_p <= reg_rd;
    sl_p <= slot_valid;
  end
  // compare on the falling edge, outputs settled by then
  always @(negedge clk)
  begin
    if (rd_p)
      check_rd(rd_q.pop_front());
    if (sl_p)
      check_sl(sl_q.pop_front());
  end

  // shared mismatch path for both kinds
  task automatic cmp(input logic [37:0] g, e);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic check_rd(input logic [7:0] e);
    cmp({30'h0, reg_rdata}, {30'h0, e});
  endtask
  // write data and bits only mean something on a write, index only with an event
  task automatic check_sl(input logic [37:0] e);
    logic [37:0] m;
    m = {38{1'b1}};
    if (!e[35])
      m[16:5] = 12'h0;
    if (!e[37])
      m[4:0] = 5'h0;
    cmp(m & {fifo_event, fifo_rd_take, fifo_wr_valid, line_tx_valid, line_tx_data,
        pcm_tx_valid, pcm_tx_data, fifo_wr_data, fifo_bits, fifo_index}, m & e);
  endtask

  // expected slot result: {event,take,write,line v/d,pcm v/d,wdata,bits,index}
  function automatic logic [37:0] model(input logic [4:0] o, input logic [7:0] c, s, fd, lr, pr);
    logic [7:0] v, b, w;
    logic [2:0] f;
    logic       u;
    int         n;
    f = c[7:5];
    u = f[2:1] != 2'h3;
    n = (s[2:0] == 3'h0) ? 8 : s[2:0];
    // invert, then place or extract at start bit
    v = o[0] ? (f[0] ? pr : lr) : fd;
    v = s[7] ? ~v : v;
    b = 8'hFF;
    w = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      b[s[5:3] + i] = v[i];
      w[i] = v[s[5:3] + i];
    end
    if (c[4:2] == 3'h0)
      return {4'h0, 8'hFF, 1'b0, 8'hFF, 17'h0};
    // transmit routing, loop holds the fifo entry
    if (!o[0])
      return {u, u && !(s[6] && c[1]), 1'b0, !f[1], f[1] ? 8'hFF : b, 1'b1, f[2] ? lr : b,
              12'h0, o};
    // receive routing, pcm feed stored only when flow bit 0 picks pcm
    return {3'h5, f[1], f[1] ? pr : 8'hFF, 1'b0, 8'hFF, w, c[1] ? 4'h8 : n[3:0], o};
  endfunction

  // one register cycle; strobes assigned once per cycle
  task automatic reg_op(input logic w, r, input logic [7:0] a, d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    slot_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, e);
    rd_q.push_back(e);
    reg_op(1'b0, 1'b1, a, 8'h00);
  endtask
  // one slot s with random data, owner o configured with c and b
  task automatic slot(input logic [4:0] s, o, input logic [7:0] c, b);
    logic [7:0] fd, lr, pr;
    fd = 8'($random(seed));
    lr = 8'($random(seed));
    pr = 8'($random(seed));
    sl_q.push_back(model(o, c, b, fd, lr, pr));
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    slot_valid <= 1'b1;
    slot_num <= s[4:1];
    slot_dir <= s[0];
    fifo_rd_data <= fd;
    line_rx_data <= lr;
    pcm_rx_data <= pr;
    @(posedge clk);
  endtask

  task automatic test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // the run needs well under 1000 cycles
  initial
  begin
    #250000;
    failures++;
    test_done;
  end

  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    // each fifo starts on its own slot
    for (int i = 0; i < 32; i++)
    begin
      reg_op(1'b1, 1'b0, 8'h0F, 8'(i));
      rd(8'hFC, 8'(i));
      rd(8'hFB, 8'h00);
    end
    // channel register written and read back, unmapped place reads zero
    reg_op(1'b1, 1'b0, 8'h0F, 8'h03);
    reg_op(1'b1, 1'b0, 8'hFC, 8'h1F);
    rd(8'hFC, 8'h1F);
    rd(8'h10, 8'h00);
    // every flow code, both directions, random setup
    for (int i = 0; i < 64; i++)
    begin
      ix = 5'($random(seed));
      ix[0] = i[3];
      cn = 8'($random(seed));
      cn[7:5] = i[2:0];
      sb = 8'($random(seed));
      // keep count plus start inside the byte
      if (sb[2:0] == 3'h0)
        sb[5:3] = 3'h0;
      else if (sb[2:0] + sb[5:3] > 7)
        sb[5:3] = 3'h7 - sb[2:0];
      // select the fifo before its own registers
      reg_op(1'b1, 1'b0, 8'h0F, {3'h0, ix});
      reg_op(1'b1, 1'b0, 8'hFA, cn);
      reg_op(1'b1, 1'b0, 8'hFB, sb);
      rd(8'hFB, sb);
      rd(8'hFA, cn);
      // route status: enable, then the paths that the flow code opens
      rd(8'h0E, (cn[4:2] == 3'h0) ? 8'h00 : ix[0] ? {1'b0, cn[6], cn[5], !cn[5], 4'h1}
         : {4'h0, cn[7], !cn[7], !cn[6], 1'b1});
      slot(ix, ix, cn, sb);
      slot(ix, ix, cn, sb);
    end
    // fifo 3 moved to slot 31 only counts in select and sequence modes
    reg_op(1'b1, 1'b0, 8'h0F, 8'h03);
    reg_op(1'b1, 1'b0, 8'hFA, 8'h04);
    // fifo 3 serves a d channel, subchannel register fixed value
    reg_op(1'b1, 1'b0, 8'hFB, 8'h02);
    for (int m = 1; m < 3; m++)
    begin
      reg_op(1'b1, 1'b0, 8'h0D, 8'(m));
      slot(5'h1F, 5'h03, 8'h04, 8'h02);
      slot(5'h03, 5'h03, 8'h00, 8'h02);
    end
    reg_op(1'b1, 1'b0, 8'h0D, 8'h00);
    slot(5'h03, 5'h03, 8'h04, 8'h02);
    reg_op(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    test_done;
  end
endmodule

bind fcrsc_top fcrsc_checker i_chk
(
  .clk, .resetn, .reg_rd, .reg_rdata, .slot_valid, .fifo_rd_take, .fifo_wr_valid,
  .fifo_bits, .fifo_index, .fifo_event, .line_tx_valid, .line_tx_data, .pcm_tx_valid,
  .pcm_tx_data
);
`default_nettype wire
